// ---- shared/uart_pkg.sv ----
/*
 * constants, register map and state carrier for the serial port (modes 0, 1, 2).
 * assumes an 8-bit register port and a single system clock.
 */
package uart_pkg;
   // register offsets
   localparam logic [7:0] ADDR_PENDING = 8'hd0;
   localparam logic [7:0] ADDR_DATA = 8'hf9;
   localparam logic [7:0] ADDR_CONTROL = 8'hfa;
   localparam logic [7:0] ADDR_DIVISOR = 8'hfb;
   // control register fields
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_TX_NINTH = 3;
   localparam int CTL_RX_NINTH = 2;
   localparam int CTL_RX_IRQ_EN = 1;
   localparam int CTL_TX_IRQ_EN = 0;
   // pending register fields
   localparam int PND_RX_DONE = 5;
   localparam int PND_TX_DONE = 4;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;
   // mode encodings
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_ASYNC9 = 2'h2;
   // sixteen ticks per bit
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hf;
   // bit counters: last frame position after the start bit, or after bit 0 in mode 0
   localparam logic [3:0] M0_LAST_BIT = 4'h7;
   localparam logic [3:0] ASYNC8_LAST = 4'h9;
   localparam logic [3:0] ASYNC9_LAST = 4'ha;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_bus_t;

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] divisor;
      logic rx_done;
      logic tx_done;
      logic [7:0] rx_buf;
      logic [7:0] rdata;
      logic sync1;
      logic sync2;
      logic [7:0] pre;
      logic busy;
      logic m0_rx;
      logic [3:0] tph;
      logic [3:0] tcnt;
      logic [10:0] tsh;
      logic txd;
      logic rxd_out;
      logic rxd_oe;
      logic rx_act;
      logic [3:0] rph;
      logic [3:0] rcnt;
      logic [8:0] rsh;
   } uart_state_t;
endpackage

// ---- hw/uart_modes.sv ----
/*
 * serial port: synchronous shifter (mode 0), 10-bit and 11-bit async frames
 * (modes 1, 2; code 3 runs an 11-bit frame at the divisor rate).
 * assumes a single-cycle register port on clk_sys and a remote device on rxd/txd.
 */
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module uart_modes (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire uart_pkg::reg_bus_t bus,
   output logic [7:0] rdata,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd,
   output logic serial_irq_line
);
   uart_pkg::uart_state_t s_r, s_nxt;
   logic [1:0] mode;
   logic tick;
   logic [3:0] rx_last;

   assign mode = s_r.control[uart_pkg::CTL_MODE_HI:uart_pkg::CTL_MODE_LO];
   assign rx_last = (mode == uart_pkg::MODE_ASYNC8) ? uart_pkg::ASYNC8_LAST
                                                    : uart_pkg::ASYNC9_LAST;

   always_comb begin
      s_nxt = s_r;
      // rxd is foreign: two flops before use
      s_nxt.sync1 = rxd_in;
      s_nxt.sync2 = s_r.sync1;
      // prescaler gives the x16 tick
      tick = 1'b0;
      if (mode == uart_pkg::MODE_ASYNC9) begin
         s_nxt.pre = '0;
         tick = 1'b1;
      end else if (s_r.pre >= s_r.divisor) begin
         s_nxt.pre = '0;
         tick = 1'b1;
      end else begin
         s_nxt.pre = s_r.pre + 8'h01;
      end
      // register reads, answer in the next cycle
      s_nxt.rdata = '0;
      if (bus.rd) begin
         unique case (bus.addr)
            uart_pkg::ADDR_DATA: s_nxt.rdata = s_r.rx_buf;
            uart_pkg::ADDR_CONTROL: s_nxt.rdata = s_r.control;
            uart_pkg::ADDR_DIVISOR: s_nxt.rdata = s_r.divisor;
            uart_pkg::ADDR_PENDING: begin
               s_nxt.rdata[uart_pkg::PND_RX_DONE] = s_r.rx_done;
               s_nxt.rdata[uart_pkg::PND_TX_DONE] = s_r.tx_done;
            end
            default: s_nxt.rdata = '0;
         endcase
      end
      // register writes; hardware sets below win over these
      if (bus.wr && bus.addr == uart_pkg::ADDR_CONTROL) begin
         s_nxt.control = bus.wdata;
      end
      if (bus.wr && bus.addr == uart_pkg::ADDR_DIVISOR) begin
         s_nxt.divisor = bus.wdata;
      end
      if (bus.wr && bus.addr == uart_pkg::ADDR_PENDING) begin
         s_nxt.rx_done = bus.wdata[uart_pkg::PND_RX_DONE];
         s_nxt.tx_done = bus.wdata[uart_pkg::PND_TX_DONE];
      end
      // mode 0 receive start
      if (mode == uart_pkg::MODE_SYNC && !s_r.busy && s_r.control[uart_pkg::CTL_RX_ENABLE]
          && !s_r.rx_done) begin
         s_nxt.busy = 1'b1;
         s_nxt.m0_rx = 1'b1;
         s_nxt.tph = '0;
         s_nxt.tcnt = '0;
      end
      // shifter: mode 0 both ways, async transmit
      if (s_r.busy && tick) begin
         s_nxt.tph = s_r.tph + 4'h1;
         if (mode == uart_pkg::MODE_SYNC) begin
            if (s_r.m0_rx && s_r.tph == uart_pkg::TICK_MID) begin
               // sampled on the rising shift clock edge
               s_nxt.tsh[7:0] = {s_r.sync2, s_r.tsh[7:1]};
            end
            if (s_r.tph == uart_pkg::TICK_LAST) begin
               s_nxt.tcnt = s_r.tcnt + 4'h1;
               if (!s_r.m0_rx) begin
                  s_nxt.tsh = {1'b1, s_r.tsh[10:1]};
               end
               if (s_r.tcnt == uart_pkg::M0_LAST_BIT) begin
                  s_nxt.busy = 1'b0;
                  s_nxt.m0_rx = 1'b0;
                  if (s_r.m0_rx) begin
                     s_nxt.rx_done = 1'b1;
                     s_nxt.rx_buf = s_r.tsh[7:0];
                  end else begin
                     s_nxt.tx_done = 1'b1;
                  end
               end
            end
         end else if (s_r.tph == uart_pkg::TICK_LAST) begin
            s_nxt.tsh = {1'b1, s_r.tsh[10:1]};
            s_nxt.tcnt = s_r.tcnt + 4'h1;
            if (s_r.tcnt == rx_last - 4'h1) begin
               s_nxt.tx_done = 1'b1;
            end
            if (s_r.tcnt == rx_last) begin
               s_nxt.busy = 1'b0;
            end
         end
      end
      // async receiver
      if (mode == uart_pkg::MODE_SYNC) begin
         s_nxt.rx_act = 1'b0;
      end else if (!s_r.rx_act) begin
         if (s_r.control[uart_pkg::CTL_RX_ENABLE] && !s_r.sync2) begin
            s_nxt.rx_act = 1'b1;
            s_nxt.rph = '0;
            s_nxt.rcnt = '0;
         end
      end else if (tick) begin
         s_nxt.rph = s_r.rph + 4'h1;
         if (s_r.rph == uart_pkg::TICK_MID) begin
            if (s_r.rcnt == 4'h0) begin
               // a start bit gone high by mid bit was a glitch
               if (s_r.sync2) begin
                  s_nxt.rx_act = 1'b0;
               end else begin
                  s_nxt.rcnt = 4'h1;
               end
            end else if (s_r.rcnt == rx_last) begin
               s_nxt.rx_act = 1'b0;
               s_nxt.rx_done = 1'b1;
               // an unread byte is overwritten here
               if (mode == uart_pkg::MODE_ASYNC8) begin
                  s_nxt.rx_buf = s_r.rsh[8:1];
                  s_nxt.control[uart_pkg::CTL_RX_NINTH] = s_r.sync2;
               end else begin
                  s_nxt.rx_buf = s_r.rsh[7:0];
                  s_nxt.control[uart_pkg::CTL_RX_NINTH] = s_r.rsh[8];
               end
            end else begin
               s_nxt.rsh = {s_r.sync2, s_r.rsh[8:1]};
               s_nxt.rcnt = s_r.rcnt + 4'h1;
            end
         end
      end
      // data write restarts the shifter at once
      if (bus.wr && bus.addr == uart_pkg::ADDR_DATA) begin
         s_nxt.busy = 1'b1;
         s_nxt.m0_rx = 1'b0;
         s_nxt.tph = '0;
         s_nxt.tcnt = '0;
         if (mode == uart_pkg::MODE_SYNC) begin
            s_nxt.tsh = {3'h7, bus.wdata};
         end else if (mode == uart_pkg::MODE_ASYNC8) begin
            s_nxt.tsh = {2'h3, bus.wdata, 1'b0};
         end else begin
            s_nxt.tsh = {1'b1, s_r.control[uart_pkg::CTL_TX_NINTH], bus.wdata, 1'b0};
         end
      end
      // pins from flops
      if (!s_nxt.busy) begin
         s_nxt.txd = 1'b1;
      end else if (mode == uart_pkg::MODE_SYNC) begin
         s_nxt.txd = s_nxt.tph[3]; // low first half, rises mid bit
      end else begin
         s_nxt.txd = s_nxt.tsh[0];
      end
      s_nxt.rxd_out = s_nxt.tsh[0];
      // next mode, so a control write never leaves rxd driven in an async mode
      s_nxt.rxd_oe = s_nxt.busy && !s_nxt.m0_rx
         && s_nxt.control[uart_pkg::CTL_MODE_HI:uart_pkg::CTL_MODE_LO] == uart_pkg::MODE_SYNC;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.control <= uart_pkg::CONTROL_RESET;
         s_r.divisor <= uart_pkg::DIVISOR_RESET;
         s_r.sync1 <= 1'b1;
         s_r.sync2 <= 1'b1;
         s_r.txd <= 1'b1;
         s_r.rxd_out <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign txd = s_r.txd;
   assign rxd_out = s_r.rxd_out;
   assign rxd_oe = s_r.rxd_oe;
   // tx irq enable also feeds the shared line; only rx irq enable gates rx done
   assign serial_irq_line = (s_r.rx_done && s_r.control[uart_pkg::CTL_RX_IRQ_EN])
      || (s_r.tx_done && s_r.control[uart_pkg::CTL_TX_IRQ_EN]);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   logic data_wr;
   assign data_wr = bus.wr && bus.addr == uart_pkg::ADDR_DATA;

   AST_RXD_DRIVE: assert property (rxd_oe |-> mode == uart_pkg::MODE_SYNC && !s_r.m0_rx)
      else $error("rxd driven outside mode 0 transmit");
   AST_M0_LSB: assert property (data_wr && mode == uart_pkg::MODE_SYNC && !bus.rd
      ##1 !bus.wr [*1] |-> rxd_oe && rxd_out == $past(bus.wdata[0]))
      else $error("mode 0 does not start with bit 0");
   AST_TX_START: assert property (data_wr |=> s_r.busy && s_r.tcnt == 4'h0)
      else $error("data write did not start the shifter");
   AST_M0_RX_GATE: assert property ($rose(s_r.m0_rx) |->
      $past(!s_r.rx_done && s_r.control[uart_pkg::CTL_RX_ENABLE]))
      else $error("mode 0 receive started while not allowed");
   AST_M0_RX_PIN: assert property (s_r.m0_rx |-> !rxd_oe)
      else $error("rxd driven during mode 0 receive");
   AST_IRQ_MASK: assert property (!s_r.control[uart_pkg::CTL_RX_IRQ_EN]
      && !(s_r.tx_done && s_r.control[uart_pkg::CTL_TX_IRQ_EN]) |-> !serial_irq_line)
      else $error("interrupt raised while masked");
   AST_START_BIT: assert property (data_wr && mode != uart_pkg::MODE_SYNC
      && !(bus.wr && bus.addr == uart_pkg::ADDR_CONTROL) |=> !txd [*8])
      else $error("start bit missing");
   AST_TIP_AT_STOP: assert property ($rose(s_r.tx_done) && mode != uart_pkg::MODE_SYNC
      && !$past(bus.wr) |-> txd)
      else $error("tx done not at stop bit");
   AST_RX_BEGIN: assert property (mode != uart_pkg::MODE_SYNC && !s_r.rx_act
      && s_r.control[uart_pkg::CTL_RX_ENABLE] && !s_r.sync2
      && $stable(mode) ##1 $stable(mode) |-> s_r.rx_act)
      else $error("low rxd did not start reception");
   AST_M2_RATE: assert property (mode == uart_pkg::MODE_ASYNC9 |-> tick)
      else $error("mode 2 tick not every clock");
   AST_RX_FLAG: assert property ($rose(s_r.rx_done) && mode != uart_pkg::MODE_SYNC
      && !$past(bus.wr) |-> $past(s_r.rph) == uart_pkg::TICK_MID)
      else $error("rx done not at mid stop bit");

   // shift clock and idle level on txd
   AST_M0_CLOCK: assert property (s_r.busy && mode == uart_pkg::MODE_SYNC && $stable(mode)
      |-> txd == s_r.tph[3])
      else $error("mode 0 shift clock out of phase");
   AST_TXD_IDLE: assert property (!s_r.busy |-> txd)
      else $error("txd not high while idle");

   // shifter loads; the data write is the last word on tsh
   AST_M0_LOAD: assert property (data_wr && mode == uart_pkg::MODE_SYNC
      |=> s_r.tsh[7:0] == $past(bus.wdata) && !s_r.m0_rx)
      else $error("mode 0 shifter not loaded");
   AST_M1_LOAD: assert property (data_wr && mode == uart_pkg::MODE_ASYNC8
      |=> s_r.tsh == {2'h3, $past(bus.wdata), 1'b0})
      else $error("mode 1 frame not framed");
   AST_M2_NINTH_TX: assert property (data_wr && mode == uart_pkg::MODE_ASYNC9
      |=> s_r.tsh[9] == $past(s_r.control[uart_pkg::CTL_TX_NINTH]))
      else $error("mode 2 ninth bit not loaded");
   AST_TX_END: assert property (s_r.busy && mode != uart_pkg::MODE_SYNC && tick
      && s_r.tph == uart_pkg::TICK_LAST && s_r.tcnt == rx_last && !data_wr
      |=> !s_r.busy)
      else $error("async frame longer than its bit count");

   // mode 0 receive
   AST_M0_SAMPLE: assert property (s_r.busy && s_r.m0_rx && mode == uart_pkg::MODE_SYNC
      && tick && s_r.tph == uart_pkg::TICK_MID && !data_wr
      |=> s_r.tsh[7] == $past(s_r.sync2))
      else $error("mode 0 bit not sampled at rising clock");
   AST_M0_HOLD: assert property (s_r.rx_done && mode == uart_pkg::MODE_SYNC && !s_r.busy
      && !data_wr |=> !s_r.busy)
      else $error("mode 0 receive started with flag set");

   // flags rise only at the frame positions the rules name
   AST_M0_RX_FLAG: assert property ($rose(s_r.rx_done) && $past(mode) == uart_pkg::MODE_SYNC
      && !$past(bus.wr) |-> $past(s_r.tcnt) == uart_pkg::M0_LAST_BIT
      && $past(s_r.tph) == uart_pkg::TICK_LAST)
      else $error("mode 0 rx done not after eighth bit");
   AST_M0_TX_FLAG: assert property ($rose(s_r.tx_done) && $past(mode) == uart_pkg::MODE_SYNC
      && !$past(bus.wr) |-> $past(s_r.tcnt) == uart_pkg::M0_LAST_BIT)
      else $error("mode 0 tx done not after eighth bit");

   // async receive results
   AST_M1_STOP_STORE: assert property ($rose(s_r.rx_done)
      && $past(mode) == uart_pkg::MODE_ASYNC8 && !$past(bus.wr)
      |-> s_r.control[uart_pkg::CTL_RX_NINTH] == $past(s_r.sync2)
      && s_r.rx_buf == $past(s_r.rsh[8:1]))
      else $error("mode 1 stop bit or data not stored");
   AST_M2_NINTH_STORE: assert property ($rose(s_r.rx_done)
      && $past(mode) == uart_pkg::MODE_ASYNC9 && !$past(bus.wr)
      |-> s_r.control[uart_pkg::CTL_RX_NINTH] == $past(s_r.rsh[8])
      && s_r.rx_buf == $past(s_r.rsh[7:0]))
      else $error("mode 2 ninth bit or data not stored");
   AST_GLITCH: assert property (s_r.rx_act && tick && mode != uart_pkg::MODE_SYNC
      && s_r.rph == uart_pkg::TICK_MID && s_r.rcnt == 4'h0 && s_r.sync2
      |=> !s_r.rx_act)
      else $error("high start bit not rejected");

   // clocks since the last tick; a divisor or control write voids the gap in flight,
   // since the prescaler may then end one period early
   logic [8:0] gap_r;
   logic gap_ok_r;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         gap_r <= 9'h001;
         gap_ok_r <= 1'b0;
      end else begin
         if (tick) begin
            gap_r <= 9'h001;
         end else begin
            gap_r <= gap_r + 9'h001;
         end
         if (bus.wr && (bus.addr == uart_pkg::ADDR_DIVISOR
             || bus.addr == uart_pkg::ADDR_CONTROL)) begin
            gap_ok_r <= 1'b0;
         end else if (tick) begin
            gap_ok_r <= 1'b1;
         end
      end
   end

   AST_BAUD_GAP: assert property (tick && gap_ok_r && mode != uart_pkg::MODE_ASYNC9
      |-> gap_r == {1'b0, s_r.divisor} + 9'h001)
      else $error("tick period not divisor plus one");

   COV_M0_TX: cover property (data_wr && mode == uart_pkg::MODE_SYNC ##[1:300] $rose(s_r.tx_done));
   COV_M0_RX: cover property ($rose(s_r.m0_rx) ##[1:300] $rose(s_r.rx_done));
   COV_M1_RX: cover property (mode == uart_pkg::MODE_ASYNC8 && $rose(s_r.rx_done));
   COV_M2_TX: cover property (mode == uart_pkg::MODE_ASYNC9 && $rose(s_r.tx_done));
   COV_M2_RX: cover property (mode == uart_pkg::MODE_ASYNC9 && $rose(s_r.rx_done));
endmodule

// ---- test/serial_peer.sv ----
/*
 * remote serial device on the rxd line: async frames, glitches, mode 0 bytes.
 * assumes the bench resolves rxd from this line and the port's rxd_oe/rxd_out.
 */
`timescale 1ns/100ps
module serial_peer (
   input wire logic clk_sys,
   input wire logic txd,
   output logic line
);
   // line has a pull-up: released means high
   initial line = 1'b1;

   // bit 0 of bits goes out first
   task automatic send_async(input logic [10:0] bits, input int n, input int bitclk);
      for (int i = 0; i < n; i++) begin
         line <= bits[i];
         repeat (bitclk) @(posedge clk_sys);
      end
      line <= 1'b1;
   endtask

   // short low pulse, too short to be a start bit
   task automatic glitch(input int len);
      line <= 1'b0;
      repeat (len) @(posedge clk_sys);
      line <= 1'b1;
   endtask

   // changes data on falling shift clock, port samples on rising
   task automatic send_sync(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         line <= d[i];
         @(posedge txd);
         if (i < 7) begin
            @(negedge txd);
         end
      end
      repeat (4) @(posedge clk_sys);
      line <= 1'b1;
   endtask
endmodule

// ---- test/test_uart_modes.sv ----
/*
 * bench for the serial port: register tasks, frame checks on txd, peer-driven receive.
 * assumes serial_peer on rxd and the single-cycle register port of uart_modes.
 */
`timescale 1ns/100ps
module test_uart_modes;
   logic clk_sys;
   logic resetn;
   uart_pkg::reg_bus_t bus;
   logic [7:0] rdata;
   logic rxd_out;
   logic rxd_oe;
   logic txd;
   logic serial_irq_line;
   logic peer_line;
   logic rxd_in;
   logic [7:0] v;
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   assign rxd_in = rxd_oe ? rxd_out : peer_line;

   uart_modes uart_modes_i (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata),
      .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
      .serial_irq_line(serial_irq_line));
   serial_peer serial_peer_i (.clk_sys(clk_sys), .txd(txd), .line(peer_line));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // sampled just after the edge so edge updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      check(rdata, exp, what);
   endtask

   // bounded wait for a txd level
   task automatic wait_txd(input logic lvl);
      for (int k = 0; k < 200 && txd !== lvl; k++) begin
         tick(1);
      end
   endtask

   // samples each bit at its middle, bit 0 first
   task automatic chk_frame(input logic [10:0] bits, input int n, input int bitclk);
      wait_txd(1'b0);
      tick(bitclk / 2);
      for (int i = 0; i < n; i++) begin
         check({7'h00, txd}, {7'h00, bits[i]}, "tx bit");
         tick(bitclk);
      end
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("unexpected at %0t: run too long", $time);
         tally_and_finish();
      end
   end

   initial begin
      resetn = 1'b0;
      bus = '0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      tick(1);
      check({txd, rxd_oe, serial_irq_line, 5'h00}, 8'h80, "idle pins");
      rd_chk(uart_pkg::ADDR_CONTROL, uart_pkg::CONTROL_RESET, "control reset");
      rd_chk(uart_pkg::ADDR_DIVISOR, uart_pkg::DIVISOR_RESET, "divisor reset");
      rd_chk(8'h55, 8'h00, "unmapped");
      // mode 1 at divisor 0 and 1: 16 then 32 clocks a bit
      wr(uart_pkg::ADDR_CONTROL, 8'h40);
      wr(uart_pkg::ADDR_DATA, 8'ha5);
      chk_frame({1'b0, 1'b1, 8'ha5, 1'b0}, 10, 16);
      rd_chk(uart_pkg::ADDR_PENDING, 8'h10, "tx done");
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      wr(uart_pkg::ADDR_DIVISOR, 8'h01);
      wr(uart_pkg::ADDR_DATA, 8'h3c);
      chk_frame({1'b0, 1'b1, 8'h3c, 1'b0}, 10, 32);
      // mode 2 ignores the divisor
      wr(uart_pkg::ADDR_DIVISOR, 8'h03);
      wr(uart_pkg::ADDR_CONTROL, 8'h88);
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      wr(uart_pkg::ADDR_DATA, 8'h5a);
      chk_frame({1'b1, 1'b1, 8'h5a, 1'b0}, 11, 16);
      rd_chk(uart_pkg::ADDR_PENDING, 8'h10, "tx done m2");
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      // mode 1 receive, stop bit lands in control bit 2
      wr(uart_pkg::ADDR_DIVISOR, 8'h00);
      wr(uart_pkg::ADDR_CONTROL, 8'h52);
      tick(2);
      serial_peer_i.send_async({1'b0, 1'b1, 8'h5a, 1'b0}, 10, 16);
      tick(30);
      check({7'h00, serial_irq_line}, 8'h01, "irq on");
      rd_chk(uart_pkg::ADDR_DATA, 8'h5a, "rx m1");
      rd_chk(uart_pkg::ADDR_CONTROL, 8'h56, "stop bit");
      rd_chk(uart_pkg::ADDR_PENDING, 8'h20, "rx done");
      wr(uart_pkg::ADDR_CONTROL, 8'h50);
      tick(1);
      check({7'h00, serial_irq_line}, 8'h00, "irq masked");
      // a 3-clock low pulse fails the mid start check
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      tick(2);
      serial_peer_i.glitch(3);
      tick(300);
      rd_chk(uart_pkg::ADDR_PENDING, 8'h00, "glitch");
      // mode 2 receive: ninth bit 0 overwrites a preset 1, stop ignored
      wr(uart_pkg::ADDR_DIVISOR, 8'h03);
      wr(uart_pkg::ADDR_CONTROL, 8'h94);
      tick(2);
      serial_peer_i.send_async({1'b1, 1'b0, 8'hc3, 1'b0}, 11, 16);
      tick(30);
      rd_chk(uart_pkg::ADDR_DATA, 8'hc3, "rx m2");
      rd_chk(uart_pkg::ADDR_CONTROL, 8'h90, "ninth bit");
      // mode 0 transmit: data on rxd, sampled at rising shift clock
      wr(uart_pkg::ADDR_DIVISOR, 8'h00);
      wr(uart_pkg::ADDR_CONTROL, 8'h00);
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      v = 8'h96;
      wr(uart_pkg::ADDR_DATA, v);
      for (int i = 0; i < 8; i++) begin
         wait_txd(1'b0);
         wait_txd(1'b1);
         check({6'h00, rxd_oe, rxd_out}, {6'h00, 1'b1, v[i]}, "m0 tx bit");
      end
      tick(20);
      rd_chk(uart_pkg::ADDR_PENDING, 8'h10, "m0 tx done");
      // mode 0 receive, peer shifts a byte in
      wr(uart_pkg::ADDR_PENDING, 8'h00);
      fork
         serial_peer_i.send_sync(8'h4b);
      join_none
      wr(uart_pkg::ADDR_CONTROL, 8'h10);
      tick(170);
      rd_chk(uart_pkg::ADDR_DATA, 8'h4b, "m0 rx");
      rd_chk(uart_pkg::ADDR_PENDING, 8'h20, "m0 rx done");
      // flag still set: no new shift clock
      v = 8'h00;
      for (int k = 0; k < 40; k++) begin
         tick(1);
         v = v | {7'h00, ~txd};
      end
      check(v, 8'h00, "m0 idle");
      wr(uart_pkg::ADDR_CONTROL, 8'h00);
      tally_and_finish();
   end
endmodule
